// ===== pkg/dcr_regs.vh
// Purpose: register offsets, field positions and reset values of the channel register block
// Assumes: byte addresses on an 8-bit APB address, one 32-bit word per register
// Notes:   included by every design file of the block
`ifndef DCR_REGS_VH
`define DCR_REGS_VH

`define DCR_ADDR_W          8
`define DCR_OFS_CH1_COUNT   8'h0c
`define DCR_OFS_CH1_PBASE   8'h10
`define DCR_OFS_CH1_MBASE   8'h14
`define DCR_OFS_CH2_CTRL    8'h1c
`define DCR_OFS_CH1_MODE    8'h40
`define DCR_OFS_CH1_STATUS  8'h44
`define DCR_OFS_CH1_PPTR    8'h48
`define DCR_OFS_CH1_MPTR    8'h4c

`define DCR_RST_COUNT       16'h0000
`define DCR_RST_ADDR        32'h00000000
`define DCR_RST_CTRL        15'h0000
`define DCR_CTRL_W          15

`define DCR_BIT_ENABLE      0
`define DCR_BIT_DONE_IRQ    1
`define DCR_BIT_HALF_IRQ    2
`define DCR_BIT_ERR_IRQ     3
`define DCR_BIT_DIR         4
`define DCR_BIT_WRAP        5
`define DCR_BIT_PSTEP       6
`define DCR_BIT_MSTEP       7
`define DCR_FLD_PWIDTH_LO   8
`define DCR_FLD_PWIDTH_HI   9
`define DCR_FLD_MWIDTH_LO   10
`define DCR_FLD_MWIDTH_HI   11
`define DCR_FLD_PRIO_LO     12
`define DCR_FLD_PRIO_HI     13
`define DCR_BIT_M2M         14

`define DCR_WIDTH_8         2'b00
`define DCR_WIDTH_16        2'b01
`define DCR_WIDTH_32        2'b10

`endif

// ===== src/dcr_addr_gen.v
// Purpose: current transfer address of one side of channel 1
// Assumes: advance is a single-cycle pulse on pclk
// Notes:   pointer is stored already aligned, so its output is a flip-flop
`timescale 1ns/100ps
`include "dcr_regs.vh"

module dcr_addr_gen (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [31:0] base,
  input  wire [1:0]  width,
  input  wire        step_on,
  input  wire        track,
  input  wire        restart,
  input  wire        advance,
  output wire [31:0] addr
);

  reg [31:0] ptr_q;

  // drop low bits that the element width ignores
  function [31:0] align_addr;
    input [31:0] a;
    input [1:0]  w;
    begin
      case (w)
        `DCR_WIDTH_16: align_addr = {a[31:1], 1'b0};
        `DCR_WIDTH_32: align_addr = {a[31:2], 2'b00};
        default:       align_addr = a;
      endcase
    end
  endfunction

  // bytes per element
  function [31:0] elem_bytes;
    input [1:0] w;
    begin
      case (w)
        `DCR_WIDTH_16: elem_bytes = 32'h00000002;
        `DCR_WIDTH_32: elem_bytes = 32'h00000004;
        default:       elem_bytes = 32'h00000001;
      endcase
    end
  endfunction

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= `DCR_RST_ADDR;
    end else if (track || restart) begin
      ptr_q <= align_addr(base, width);      // see [R8] see [R10]
    end else if (advance && step_on) begin
      ptr_q <= align_addr(ptr_q + elem_bytes(width), width); // see [R15] see [R16] see [R23]
    end
  end

  assign addr = ptr_q;

endmodule

// ===== src/dcr_top.v
// Purpose: channel register block, APB slave with channel 1 count and addresses, channel 2 control
// Assumes: ch1_xfer_done comes from the datapath on pclk, one pulse per completed item
// Notes:   zero-wait APB, one access cycle per transfer
//
// Functional notes
// [R1] remaining count is 16 bits, 0 to 65535, resets to zero
// [R2] count writes take effect only while channel is disabled
// [R3] while enabled, count is read-only and shows items left
// [R4] count decrements by one after each completed transfer
// [R5] at zero count stays zero, or reloads programmed value in wraparound mode
// [R6] zero count means no transfer served, whatever the enable
// [R7] 32-bit peripheral base register, read-write, resets to zero
// [R8] peripheral address ignores bit 0 at 16-bit, bits 1:0 at 32-bit
// [R9] 32-bit memory base register, read-write, resets to zero
// [R10] memory address ignores bit 0 at 16-bit, bits 1:0 at 32-bit
// [R11] control bit 14 turns on memory-to-memory copy, resets to zero
// [R12] control bits 13:12 set priority low, medium, high, very high
// [R13] control bits 11:10 select memory element width 8, 16, 32
// [R14] control bits 9:8 select peripheral element width 8, 16, 32
// [R15] control bit 7 advances memory address after each transfer
// [R16] control bit 6 advances peripheral address after each transfer
// [R17] control bit 5 turns on wraparound mode, resets to zero
// [R18] control bit 4 picks source: 0 peripheral, 1 memory
// [R19] control bit 3 lets the error event raise an interrupt
// [R20] control bit 2 lets the halfway event raise an interrupt
// [R21] control bit 1 lets the done event raise an interrupt
// [R22] control bit 0 enables the channel, resets to zero
// [R23] address step equals element width of that side: 1, 2 or 4
// [R24] software programs everything before enabling and avoids reserved widths
`timescale 1ns/100ps
`include "dcr_regs.vh"

module dcr_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        ch1_xfer_done,
  output wire        ch1_serve,
  output wire [15:0] ch1_remaining_count,
  output wire [31:0] ch1_periph_addr,
  output wire [31:0] ch1_memory_addr,
  output wire        ch1_dir,
  output wire        ch1_wrapped,
  output wire        ch2_enable,
  output wire        ch2_copy_between_memories,
  output wire [1:0]  ch2_channel_priority,
  output wire [1:0]  ch2_memory_elem_width,
  output wire [1:0]  ch2_periph_elem_width,
  output wire        ch2_memory_addr_step,
  output wire        ch2_periph_addr_step,
  output wire        ch2_wraparound_mode,
  output wire        ch2_dir,
  output wire        ch2_error_irq_on,
  output wire        ch2_halfway_irq_on,
  output wire        ch2_done_irq_on
);

  // bus state
  reg  [31:0] prdata_q;
  reg         pready_q;
  reg         pslverr_q;

  // channel 1 state
  reg  [15:0] count_q;
  reg  [15:0] count_d;
  reg  [15:0] reload_q;
  reg  [31:0] pbase_q;
  reg  [31:0] mbase_q;
  reg  [`DCR_CTRL_W-1:0] ch1_mode_q;
  reg         serve_q;
  reg         wrapped_q;
  reg         wrap_d;

  // channel 2 control word
  reg  [`DCR_CTRL_W-1:0] ch2_ctrl_q;

  wire [31:0] pptr;
  wire [31:0] mptr;

  reg  [31:0] rdata_d;
  reg         hit_d;

  wire        setup_ph;
  wire        wr_en;
  wire        ch1_en;
  wire        ch1_en_d;
  wire        step_ev;

  // true when the address is a mapped register
  function is_mapped;
    input [7:0] a;
    begin
      case (a)
        `DCR_OFS_CH1_COUNT,
        `DCR_OFS_CH1_PBASE,
        `DCR_OFS_CH1_MBASE,
        `DCR_OFS_CH2_CTRL,
        `DCR_OFS_CH1_MODE,
        `DCR_OFS_CH1_STATUS,
        `DCR_OFS_CH1_PPTR,
        `DCR_OFS_CH1_MPTR: is_mapped = 1'b1;
        default:           is_mapped = 1'b0;
      endcase
    end
  endfunction

  // write strobe for one register in the access cycle
  function wr_hit;
    input       we;
    input [7:0] a;
    input [7:0] ofs;
    begin
      wr_hit = we && (a == ofs);
    end
  endfunction

  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pwrite && pready_q;
  assign ch1_en   = ch1_mode_q[`DCR_BIT_ENABLE];

  // enable after this edge, used so serve tracks the enable without lag
  assign ch1_en_d = wr_hit(wr_en, paddr, `DCR_OFS_CH1_MODE) ?
                    pwdata[`DCR_BIT_ENABLE] : ch1_en;

  // a completed item only counts while the channel is being served
  assign step_ev  = ch1_xfer_done && serve_q;            // see [R6]

  // read mux, sampled in the setup cycle
  always @* begin
    rdata_d = 32'h00000000;
    hit_d   = is_mapped(paddr);
    case (paddr)
      `DCR_OFS_CH1_COUNT:  rdata_d = {16'h0000, count_q};      // see [R3]
      `DCR_OFS_CH1_PBASE:  rdata_d = pbase_q;
      `DCR_OFS_CH1_MBASE:  rdata_d = mbase_q;
      `DCR_OFS_CH2_CTRL:   rdata_d = {17'h00000, ch2_ctrl_q};
      `DCR_OFS_CH1_MODE:   rdata_d = {17'h00000, ch1_mode_q};
      `DCR_OFS_CH1_STATUS: rdata_d = {30'h00000000, wrapped_q, serve_q};
      `DCR_OFS_CH1_PPTR:   rdata_d = pptr;
      `DCR_OFS_CH1_MPTR:   rdata_d = mptr;
      default:             rdata_d = 32'h00000000;
    endcase
  end

  // apb answer: ready in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph && !hit_d;
      if (setup_ph && !pwrite) begin
        prdata_q <= rdata_d;
      end
    end
  end

  // next remaining count
  always @* begin
    count_d = count_q;
    wrap_d  = 1'b0;
    if (wr_hit(wr_en, paddr, `DCR_OFS_CH1_COUNT) && !ch1_en) begin
      count_d = pwdata[15:0];                            // see [R1] see [R2]
    end else if (step_ev) begin
      if (count_q == 16'h0001) begin
        if (ch1_mode_q[`DCR_BIT_WRAP]) begin
          count_d = reload_q;                            // see [R5]
          wrap_d  = 1'b1;
        end else begin
          count_d = 16'h0000;                            // see [R5]
        end
      end else begin
        count_d = count_q - 16'h0001;                    // see [R4]
      end
    end
  end

  // channel 1 registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q    <= `DCR_RST_COUNT;
      reload_q   <= `DCR_RST_COUNT;
      pbase_q    <= `DCR_RST_ADDR;
      mbase_q    <= `DCR_RST_ADDR;
      ch1_mode_q <= `DCR_RST_CTRL;
      serve_q    <= 1'b0;
      wrapped_q  <= 1'b0;
    end else begin
      count_q   <= count_d;
      wrapped_q <= wrap_d;
      serve_q   <= ch1_en_d && (count_d != 16'h0000);   // see [R6]
      if (wr_hit(wr_en, paddr, `DCR_OFS_CH1_COUNT) && !ch1_en) begin
        reload_q <= pwdata[15:0];                        // see [R2] see [R5]
      end
      if (wr_hit(wr_en, paddr, `DCR_OFS_CH1_PBASE)) begin
        pbase_q <= pwdata;                               // see [R7]
      end
      if (wr_hit(wr_en, paddr, `DCR_OFS_CH1_MBASE)) begin
        mbase_q <= pwdata;                               // see [R9]
      end
      if (wr_hit(wr_en, paddr, `DCR_OFS_CH1_MODE)) begin
        ch1_mode_q <= pwdata[`DCR_CTRL_W-1:0];
      end
    end
  end

  // channel 2 control word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_ctrl_q <= `DCR_RST_CTRL;                       // see [R11] see [R17] see [R22]
    end else if (wr_hit(wr_en, paddr, `DCR_OFS_CH2_CTRL)) begin
      ch2_ctrl_q <= pwdata[`DCR_CTRL_W-1:0];             // see [R12] see [R13] see [R14]
    end
  end

  // peripheral side pointer
  dcr_addr_gen u_pptr (
    .pclk    (pclk),
    .presetn (presetn),
    .base    (pbase_q),
    .width   (ch1_mode_q[`DCR_FLD_PWIDTH_HI:`DCR_FLD_PWIDTH_LO]),
    .step_on (ch1_mode_q[`DCR_BIT_PSTEP]),
    .track   (!ch1_en),
    .restart (wrap_d),
    .advance (step_ev),
    .addr    (pptr)
  );

  // memory side pointer
  dcr_addr_gen u_mptr (
    .pclk    (pclk),
    .presetn (presetn),
    .base    (mbase_q),
    .width   (ch1_mode_q[`DCR_FLD_MWIDTH_HI:`DCR_FLD_MWIDTH_LO]),
    .step_on (ch1_mode_q[`DCR_BIT_MSTEP]),
    .track   (!ch1_en),
    .restart (wrap_d),
    .advance (step_ev),
    .addr    (mptr)
  );

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign ch1_serve           = serve_q;
  assign ch1_remaining_count = count_q;
  assign ch1_periph_addr     = pptr;
  assign ch1_memory_addr     = mptr;
  assign ch1_dir             = ch1_mode_q[`DCR_BIT_DIR];
  assign ch1_wrapped         = wrapped_q;

  // channel 2 fields straight from the control flops
  assign ch2_enable                = ch2_ctrl_q[`DCR_BIT_ENABLE];     // see [R22]
  assign ch2_copy_between_memories = ch2_ctrl_q[`DCR_BIT_M2M];        // see [R11]
  assign ch2_channel_priority      = ch2_ctrl_q[`DCR_FLD_PRIO_HI:`DCR_FLD_PRIO_LO];     // see [R12]
  assign ch2_memory_elem_width     = ch2_ctrl_q[`DCR_FLD_MWIDTH_HI:`DCR_FLD_MWIDTH_LO]; // see [R13]
  assign ch2_periph_elem_width     = ch2_ctrl_q[`DCR_FLD_PWIDTH_HI:`DCR_FLD_PWIDTH_LO]; // see [R14]
  assign ch2_memory_addr_step      = ch2_ctrl_q[`DCR_BIT_MSTEP];      // see [R15]
  assign ch2_periph_addr_step      = ch2_ctrl_q[`DCR_BIT_PSTEP];      // see [R16]
  assign ch2_wraparound_mode       = ch2_ctrl_q[`DCR_BIT_WRAP];       // see [R17]
  assign ch2_dir                   = ch2_ctrl_q[`DCR_BIT_DIR];        // see [R18]
  assign ch2_error_irq_on          = ch2_ctrl_q[`DCR_BIT_ERR_IRQ];    // see [R19]
  assign ch2_halfway_irq_on        = ch2_ctrl_q[`DCR_BIT_HALF_IRQ];   // see [R20]
  assign ch2_done_irq_on           = ch2_ctrl_q[`DCR_BIT_DONE_IRQ];   // see [R21]

endmodule

// ===== test/dcr_chk_checker.sv
// Purpose: port-level checks of the channel register block
// Assumes: zero-wait apb slave, one clock
// Notes:   bound into dcr_top
`timescale 1ns/100ps
`include "dcr_regs.vh"
module dcr_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        ch1_xfer_done,
  input wire        ch1_serve,
  input wire [15:0] ch1_remaining_count,
  input wire        ch2_enable,
  input wire [1:0]  ch2_channel_priority,
  input wire [1:0]  ch2_memory_elem_width
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [15:0] cnt = ch1_remaining_count;
  wire        wr  = psel && penable && pwrite && pready;
  sequence setup_s; psel && !penable; endsequence
  sequence wr_ctrl_s; wr && paddr == `DCR_OFS_CH2_CTRL; endsequence
  chk_ready_once: assert property (setup_s |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  chk_serve_nonzero: assert property (ch1_serve |-> cnt != 16'h0)
    else $error("served with zero count");
  chk_count_dec: assert property (ch1_serve && ch1_xfer_done && cnt > 16'h1
    |=> cnt == $past(cnt) - 16'h1) else $error("count not decremented");
  chk_zero_stays: assert property (cnt == 16'h0 &&
    !(wr && paddr == `DCR_OFS_CH1_COUNT) |=> cnt == 16'h0) else $error("zero count moved");
  chk_count_locked: assert property (ch1_serve && cnt > 16'h1 && wr &&
    paddr == `DCR_OFS_CH1_COUNT |=> cnt == $past(cnt) - $past(ch1_xfer_done))
    else $error("locked count written");
  chk_count_hold: assert property (!ch1_xfer_done && !wr |=> $stable(cnt))
    else $error("count changed without cause");
  chk_ctrl_write: assert property (wr_ctrl_s |=>
    ch2_enable == $past(pwdata[0]) &&
    ch2_channel_priority == $past(pwdata[13:12]) &&
    ch2_memory_elem_width == $past(pwdata[11:10])) else $error("ctrl not taken");
  chk_ctrl_stable: assert property (!(wr && paddr == `DCR_OFS_CH2_CTRL) |=>
    $stable({ch2_enable, ch2_channel_priority})) else $error("ctrl moved");
  chk_count_upper: assert property (pready && !pwrite &&
    paddr == `DCR_OFS_CH1_COUNT |-> prdata[31:16] == 16'h0) else $error("count upper bits set");
endmodule
bind dcr_top dcr_chk dcr_chk_inst (
  .pclk                  (pclk),
  .presetn               (presetn),
  .psel                  (psel),
  .penable               (penable),
  .pwrite                (pwrite),
  .paddr                 (paddr),
  .pwdata                (pwdata),
  .prdata                (prdata),
  .pready                (pready),
  .ch1_xfer_done         (ch1_xfer_done),
  .ch1_serve             (ch1_serve),
  .ch1_remaining_count   (ch1_remaining_count),
  .ch2_enable            (ch2_enable),
  .ch2_channel_priority  (ch2_channel_priority),
  .ch2_memory_elem_width (ch2_memory_elem_width)
);

// ===== test/dcr_dp_model.sv
// Purpose: datapath stand-in completing one channel 1 item per request
// Assumes: go is a one-cycle request, dly from 1 to 7 cycles
// Notes:   completes even when the channel is not served, like a careless datapath
`timescale 1ns/100ps
module dcr_dp_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       go,
  input  wire [2:0] dly,
  output reg        done
);
  reg [2:0] wait_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 3'h0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (go) begin
        wait_q <= dly;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
        done   <= (wait_q == 3'h1);
      end
    end
  end
endmodule

// ===== test/test_dcr_top.sv
// Purpose: self-checking bench of the channel register block
// Assumes: apb tasks enter and leave just after a rising edge
// Notes:   ch1 runs 32-bit peripheral and 16-bit memory elements
`timescale 1ns/100ps
`include "dcr_regs.vh"
module test_dcr_top;
  reg         pclk, presetn, psel, penable, pwrite, go, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [2:0]  dly;
  wire [31:0] prdata, pa, ma;
  wire [15:0] cnt;
  wire [14:0] c2;
  wire        pready, pslverr, done, serve, dir, wrapped;
  reg  [31:0] v;
  integer     n_mismatch, checks_done, i, n_wrap;
  dcr_top dcr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch1_xfer_done(done), .ch1_serve(serve), .ch1_remaining_count(cnt),
    .ch1_periph_addr(pa), .ch1_memory_addr(ma), .ch1_dir(dir), .ch1_wrapped(wrapped),
    .ch2_enable(c2[0]), .ch2_done_irq_on(c2[1]), .ch2_halfway_irq_on(c2[2]),
    .ch2_error_irq_on(c2[3]), .ch2_dir(c2[4]), .ch2_wraparound_mode(c2[5]),
    .ch2_periph_addr_step(c2[6]), .ch2_memory_addr_step(c2[7]),
    .ch2_periph_elem_width(c2[9:8]), .ch2_memory_elem_width(c2[11:10]),
    .ch2_channel_priority(c2[13:12]), .ch2_copy_between_memories(c2[14]));
  dcr_dp_model dcr_dp_model_inst (.pclk(pclk), .presetn(presetn), .go(go), .dly(dly),
    .done(done));
  task conclude;
    begin
      if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task ck(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      ck(rd, e);
    end
  endtask
  task step(input [2:0] d);
    begin
      dly <= d;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      while (done !== 1'b1) @(posedge pclk);
      @(posedge pclk);
    end
  endtask
  // counts wraparound reload pulses
  always @(posedge pclk) begin
    if (!presetn) begin
      n_wrap <= 0;
    end else if (wrapped) begin
      n_wrap <= n_wrap + 1;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; go = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; dly = 3'h1; n_mismatch = 0; checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`DCR_OFS_CH1_COUNT, 32'h0);
    rdc(`DCR_OFS_CH1_PBASE, 32'h0);
    rdc(`DCR_OFS_CH1_MBASE, 32'h0);
    rdc(`DCR_OFS_CH2_CTRL, 32'h0);
    apb(1'b1, `DCR_OFS_CH1_PBASE, 32'h00001003);
    apb(1'b1, `DCR_OFS_CH1_MBASE, 32'h00002001);
    rdc(`DCR_OFS_CH1_PBASE, 32'h00001003);
    rdc(`DCR_OFS_CH1_MBASE, 32'h00002001);
    rdc(8'h30, 32'h0);
    ck({31'h0, err}, 32'h1);
    for (i = 0; i < 15; i = i + 1) begin
      apb(1'b1, `DCR_OFS_CH2_CTRL, (32'h1 << i) | 32'hffff8000);
      ck({17'h0, c2}, 32'h1 << i);
      rdc(`DCR_OFS_CH2_CTRL, 32'h1 << i);
    end
    for (i = 0; i < 4; i = i + 1) begin
      v = (i * 32'h00001000) | ((i == 3) ? 32'h00000600 : i * 32'h00000500);
      apb(1'b1, `DCR_OFS_CH2_CTRL, v);
      ck({17'h0, c2}, v);
    end
    apb(1'b1, `DCR_OFS_CH1_MODE, 32'h000006c0);
    apb(1'b1, `DCR_OFS_CH1_COUNT, 32'h3);
    ck(pa, 32'h00001000);
    ck(ma, 32'h00002000);
    apb(1'b1, `DCR_OFS_CH1_MODE, 32'h000006c1);
    apb(1'b1, `DCR_OFS_CH1_COUNT, 32'h9);
    rdc(`DCR_OFS_CH1_COUNT, 32'h3);
    for (i = 1; i <= 3; i = i + 1) begin
      step((i == 2) ? 3'h5 : 3'h1);
      ck({16'h0, cnt}, 32'h3 - i);
      ck(pa, 32'h00001000 + 4 * i);
      ck(ma, 32'h00002000 + 2 * i);
    end
    ck({31'h0, serve}, 32'h0);
    step(3'h1);
    ck({16'h0, cnt}, 32'h0);
    ck(pa, 32'h0000100c);
    apb(1'b1, `DCR_OFS_CH1_MODE, 32'h000006c0);
    apb(1'b1, `DCR_OFS_CH1_COUNT, 32'h2);
    apb(1'b1, `DCR_OFS_CH1_MODE, 32'h000006f1);
    ck({31'h0, dir}, 32'h1);
    step(3'h1);
    step(3'h1);
    ck({16'h0, cnt}, 32'h2);
    ck({31'h0, serve}, 32'h1);
    ck(pa, 32'h00001000);
    @(posedge pclk);
    ck(n_wrap, 32'h1);
    conclude;
  end
endmodule
